// [src/pmm_pkg.sv]
// Constants, register map and mode type of the power mode manager
package pmm_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ        = 20_000_000;
   localparam int PIN_HIGH_MS   = 2000;
   localparam int PIN_LOW_MS    = 1200;
   localparam int KEY_MIN_MS    = 2000;
   localparam int MASK_CYCLES   = (PIN_HIGH_MS + PIN_LOW_MS) * (CLK_HZ / 1000);
   localparam int KEY_CYCLES    = KEY_MIN_MS * (CLK_HZ / 1000);
   localparam int CNT_W         = 27;
   // ------------------------------------------------------------
   // Register offsets and fields
   // ------------------------------------------------------------
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] FUNC_OFS = 4'h4;
   localparam logic [3:0] CMD_OFS  = 4'h8;
   localparam logic [3:0] STAT_OFS = 4'hC;
   localparam int CTRL_SLEEP_EN_BIT = 0;
   localparam int CTRL_AIR_PIN_BIT  = 1;
   localparam int CTRL_USB_PATH_BIT = 2;
   localparam int CTRL_RWAKE_BIT    = 3;
   localparam int CTRL_W            = 4;
   localparam logic [3:0] CTRL_RST  = 4'h0;
   localparam int FUNC_W            = 3;
   localparam logic [2:0] FUNC_MIN  = 3'h0;
   localparam logic [2:0] FUNC_FULL = 3'h1;
   localparam logic [2:0] FUNC_AIR  = 3'h4;
   localparam logic [2:0] FUNC_RST  = FUNC_FULL;
   localparam int CMD_PDOWN_BIT     = 0;
   localparam int CMD_UR_CLR_BIT    = 1;
   localparam int ST_RF_BIT         = 3;
   localparam int ST_SIM_BIT        = 4;
   localparam int ST_MASK_BIT       = 5;
   localparam int ST_UR_BIT         = 6;
   localparam int ST_HOST_RDY_BIT   = 7;
   localparam int ST_W              = 8;
   // ------------------------------------------------------------
   // Operating modes
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PMM_FULL,
      PMM_MIN,
      PMM_AIR,
      PMM_SLEEP,
      PMM_OFF
   } pmm_mode_e;
endpackage

// [src/pmm_hold_timer.sv]
// Saturating counter that reports when its run input has held long enough
`timescale 1ns/1ns
module pmm_hold_timer #(
   parameter int CYCLES = 16
) (
   input  wire logic mclk_in,
   input  wire logic rst_in,
   input  wire logic ce_in,
   input  wire logic run_in,
   output wire logic done_out
);
   logic [pmm_pkg::CNT_W-1:0] cnt_reg;
   logic [pmm_pkg::CNT_W-1:0] cnt_next;
   wire  [pmm_pkg::CNT_W-1:0] limit = pmm_pkg::CNT_W'(CYCLES);

   // Saturate so a long hold never wraps back to zero
   assign done_out = (cnt_reg == limit);
   assign cnt_next = !run_in  ? '0 :
                     done_out ? cnt_reg :
                     cnt_reg + pmm_pkg::CNT_W'(1);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cnt_reg <= '0;
      end else if (ce_in) begin
         cnt_reg <= cnt_next;
      end
   end
endmodule

// [src/pmm_wb_regs.sv]
// Classic Wishbone slave holding the control registers
`timescale 1ns/1ns
module pmm_wb_regs (
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [3:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic [7:0]  status_in,
   output logic      [3:0]  ctrl_out,
   output logic      [2:0]  func_out,
   output logic             pdown_out,
   output logic             ur_clr_out
);
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire req      = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire wr       = req & wb_we_in & wb_sel_in[0];
   wire ctrl_hit = (wb_adr_in == pmm_pkg::CTRL_OFS);
   wire func_hit = (wb_adr_in == pmm_pkg::FUNC_OFS);
   wire cmd_hit  = (wb_adr_in == pmm_pkg::CMD_OFS);
   wire stat_hit = (wb_adr_in == pmm_pkg::STAT_OFS);
   wire [2:0] fval = wb_dat_in[2:0];
   wire func_ok  = (wb_dat_in[7:3] == 5'h00) &&
                   (fval == pmm_pkg::FUNC_MIN || fval == pmm_pkg::FUNC_FULL ||
                    fval == pmm_pkg::FUNC_AIR);
   // Unmapped offsets read as zero and still acknowledge
   wire [31:0] rd_next = ctrl_hit ? {28'h0000000, ctrl_out} :
                         func_hit ? {29'h00000000, func_out} :
                         stat_hit ? {24'h000000, status_in} : 32'h00000000;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
         ctrl_out   <= pmm_pkg::CTRL_RST;
         func_out   <= pmm_pkg::FUNC_RST;
         pdown_out  <= 1'b0;
         ur_clr_out <= 1'b0;
      end else if (ce_in) begin
         wb_ack_out <= req;
         if (req) begin
            wb_dat_out <= rd_next;
         end
         if (wr && ctrl_hit) begin
            ctrl_out <= wb_dat_in[pmm_pkg::CTRL_W-1:0];
         end
         if (wr && func_hit && func_ok) begin
            func_out <= fval;
         end
         pdown_out  <= wr & cmd_hit & wb_dat_in[pmm_pkg::CMD_PDOWN_BIT];
         ur_clr_out <= wr & cmd_hit & wb_dat_in[pmm_pkg::CMD_UR_CLR_BIT];
      end
   end
endmodule

// [src/pmm_top.sv]
// Operating mode manager: sleep, airplane, minimum and power-down control
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module pmm_top #(
   parameter int MASK_CYCLES   = pmm_pkg::MASK_CYCLES,
   parameter int KEY_CYCLES    = pmm_pkg::KEY_CYCLES
) (
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [3:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output wire logic [31:0] wb_dat_out,
   output wire logic        wb_ack_out,
   input  wire logic        terminal_ready_in,
   input  wire logic        host_ready_in,
   input  wire logic        radio_disable_n_in,
   input  wire logic        usb_suspend_in,
   input  wire logic        usb_bus_power_sense_in,
   input  wire logic        usb_data_in,
   input  wire logic        unsolicited_report_in,
   input  wire logic        radio_cmd_in,
   input  wire logic        power_key_n_in,
   output logic             ring_indicator_out,
   output logic             usb_remote_wakeup_out,
   output logic             rf_enable_out,
   output logic             sim_enable_out,
   output logic             paging_rx_enable_out,
   output logic             serial_enable_out,
   output logic             radio_cmd_reject_out,
   output logic      [2:0]  mode_out
);
   // ------------------------------------------------------------
   // Registers and timers
   // ------------------------------------------------------------
   logic [3:0]        ctrl;
   logic [2:0]        func;
   logic              pdown_pulse;
   logic              ur_clr;
   logic              mask_done;
   logic              key_hold_done;
   logic              ur_pend_reg;
   logic              vbus_reg;
   logic              wake_hold_reg;
   pmm_pkg::pmm_mode_e mode_reg;
   pmm_pkg::pmm_mode_e mode_next;
   pmm_pkg::pmm_mode_e base_mode;
   logic [7:0]        status;
   // Declared early: the key timer only runs in power-down
   wire               in_off = (mode_reg == pmm_pkg::PMM_OFF);

   pmm_wb_regs u_regs (
      .mclk_in    (mclk_in),
      .rst_in     (rst_in),
      .ce_in      (ce_in),
      .wb_cyc_in  (wb_cyc_in),
      .wb_stb_in  (wb_stb_in),
      .wb_we_in   (wb_we_in),
      .wb_adr_in  (wb_adr_in),
      .wb_sel_in  (wb_sel_in),
      .wb_dat_in  (wb_dat_in),
      .wb_dat_out (wb_dat_out),
      .wb_ack_out (wb_ack_out),
      .status_in  (status),
      .ctrl_out   (ctrl),
      .func_out   (func),
      .pdown_out  (pdown_pulse),
      .ur_clr_out (ur_clr)
   );

   pmm_hold_timer #(.CYCLES(MASK_CYCLES)) u_mask (
      .mclk_in  (mclk_in),
      .rst_in   (rst_in),
      .ce_in    (ce_in),
      .run_in   (1'b1),
      .done_out (mask_done)
   );

   // Power key must stay low for the whole hold time
   pmm_hold_timer #(.CYCLES(KEY_CYCLES)) u_key_hold (
      .mclk_in  (mclk_in),
      .rst_in   (rst_in),
      .ce_in    (ce_in),
      .run_in   (in_off & ~power_key_n_in),
      .done_out (key_hold_done)
   );

   // ------------------------------------------------------------
   // Qualified inputs
   // ------------------------------------------------------------
   wire mask_active = ~mask_done;
   wire sleep_en    = ctrl[pmm_pkg::CTRL_SLEEP_EN_BIT];
   wire usb_path    = ctrl[pmm_pkg::CTRL_USB_PATH_BIT];
   wire rwake_ok    = ctrl[pmm_pkg::CTRL_RWAKE_BIT];
   wire in_sleep    = (mode_reg == pmm_pkg::PMM_SLEEP);
   wire dtr_eff     = ~mask_active & terminal_ready_in;
   wire host_rdy    = ~mask_active & host_ready_in;
   wire pin_air     = ~mask_active & ctrl[pmm_pkg::CTRL_AIR_PIN_BIT] &
                      ~radio_disable_n_in;
   wire vbus_rise   = usb_bus_power_sense_in & ~vbus_reg;
   // bus power removed counts as idle bus
   wire usb_gone    = usb_suspend_in | ~usb_bus_power_sense_in;

   wire sleep_cond  = sleep_en & dtr_eff & (~usb_path | usb_gone) &
                      ~wake_hold_reg;
   wire wake_evt    = ~dtr_eff | ~sleep_en |
                      (usb_path & (usb_data_in | vbus_rise));

   assign base_mode = (func == pmm_pkg::FUNC_MIN) ? pmm_pkg::PMM_MIN :
                      (func == pmm_pkg::FUNC_AIR || pin_air) ?
                      pmm_pkg::PMM_AIR : pmm_pkg::PMM_FULL;

   // ------------------------------------------------------------
   // Mode state machine
   // ------------------------------------------------------------
   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         pmm_pkg::PMM_OFF: begin
            if (key_hold_done) begin
               mode_next = base_mode;
            end
         end
         pmm_pkg::PMM_SLEEP: begin
            if (pdown_pulse) begin
               mode_next = pmm_pkg::PMM_OFF;
            end else if (wake_evt || base_mode != pmm_pkg::PMM_FULL) begin
               mode_next = base_mode;
            end
         end
         default: begin
            if (pdown_pulse) begin
               mode_next = pmm_pkg::PMM_OFF;
            end else if (sleep_cond && base_mode == pmm_pkg::PMM_FULL) begin
               mode_next = pmm_pkg::PMM_SLEEP;
            end else begin
               mode_next = base_mode;
            end
         end
      endcase
   end

   // Sleep is only entered from full functionality
   wire nx_sleep = (mode_next == pmm_pkg::PMM_SLEEP);
   wire nx_full  = (mode_next == pmm_pkg::PMM_FULL);
   wire nx_off   = (mode_next == pmm_pkg::PMM_OFF);
   wire nx_min   = (mode_next == pmm_pkg::PMM_MIN);
   // A USB data wake keeps the bus suspended for a while; hold off re-entry
   wire hold_next = (in_sleep & wake_evt) | (wake_hold_reg & usb_path &
                    usb_gone);
   // Report flag: a new report beats a clear in the same cycle
   wire ur_next   = unsolicited_report_in | (ur_pend_reg & ~ur_clr);

   assign status = {host_rdy, ur_pend_reg, mask_active, sim_enable_out,
                    rf_enable_out, mode_reg};

   // ------------------------------------------------------------
   // State and outputs
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         mode_reg              <= pmm_pkg::PMM_FULL;
         ur_pend_reg           <= 1'b0;
         // Powered bus idles high: no false rise after reset
         vbus_reg              <= 1'b1;
         wake_hold_reg         <= 1'b0;
         ring_indicator_out    <= 1'b0;
         usb_remote_wakeup_out <= 1'b0;
         rf_enable_out         <= 1'b1;
         sim_enable_out        <= 1'b1;
         paging_rx_enable_out  <= 1'b1;
         serial_enable_out     <= 1'b1;
         radio_cmd_reject_out  <= 1'b0;
         mode_out              <= 3'h0;
      end else if (ce_in) begin
         mode_reg      <= mode_next;
         ur_pend_reg   <= ur_next;
         vbus_reg      <= usb_bus_power_sense_in;
         wake_hold_reg <= hold_next;
         ring_indicator_out <= ~mask_active & ur_next &
                               (~usb_path | ~rwake_ok);
         usb_remote_wakeup_out <= ur_next & usb_path & rwake_ok &
                                  usb_suspend_in;
         rf_enable_out        <= nx_full | nx_sleep;
         sim_enable_out       <= ~nx_min & ~nx_off;
         paging_rx_enable_out <= nx_full | nx_sleep;
         serial_enable_out    <= ~nx_off;
         radio_cmd_reject_out <= radio_cmd_in &
                                 (mode_reg == pmm_pkg::PMM_AIR ||
                                  mode_reg == pmm_pkg::PMM_MIN);
         mode_out             <= mode_next;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   AST_UART_SLEEP: assert property ($rose(in_sleep) |->
      $past(sleep_en) && $past(terminal_ready_in) && $past(mask_done))
      else $error("sleep entered without enable and terminal ready");
   AST_DTR_WAKE: assert property (ce_in && in_sleep && mask_done &&
      !terminal_ready_in |=> !in_sleep)
      else $error("terminal ready low did not wake");
   AST_RI_UART: assert property (ce_in && mask_done && !usb_path &&
      unsolicited_report_in |=> ring_indicator_out)
      else $error("ring indicator missing for report");
   AST_USB_SLEEP: assert property ($rose(in_sleep) && $past(usb_path) |->
      $past(usb_suspend_in) || !$past(usb_bus_power_sense_in))
      else $error("USB sleep without suspended bus");
   AST_USB_WAKE: assert property (ce_in && in_sleep && usb_path &&
      usb_data_in |=> !in_sleep)
      else $error("USB data did not wake");
   AST_RWAKE: assert property (ce_in && ur_pend_reg && !ur_clr &&
      usb_path && rwake_ok && usb_suspend_in |=> usb_remote_wakeup_out
      && !ring_indicator_out)
      else $error("remote wakeup not signalled");
   AST_RI_USB: assert property (ce_in && mask_done && usb_path &&
      !rwake_ok && unsolicited_report_in |=> ring_indicator_out
      && !usb_remote_wakeup_out)
      else $error("ring indicator not used without remote wakeup");
   AST_VBUS_WAKE: assert property (ce_in && in_sleep && usb_path &&
      $rose(usb_bus_power_sense_in) |=> !in_sleep)
      else $error("bus power return did not wake");
   AST_PIN_OFF: assert property (!ctrl[pmm_pkg::CTRL_AIR_PIN_BIT] &&
      ce_in && func == pmm_pkg::FUNC_FULL && !pdown_pulse &&
      !in_off && !sleep_cond && !in_sleep |=> mode_reg == pmm_pkg::PMM_FULL)
      else $error("radio-disable pin acted while disabled");
   AST_AIR_PIN: assert property (ce_in && pin_air && !in_off &&
      !pdown_pulse && func != pmm_pkg::FUNC_MIN |=>
      mode_reg == pmm_pkg::PMM_AIR)
      else $error("pin did not force airplane");
   AST_FUNC_LEGAL: assert property (1'b1 |-> func == pmm_pkg::FUNC_MIN ||
      func == pmm_pkg::FUNC_FULL || func == pmm_pkg::FUNC_AIR)
      else $error("illegal function level stored");
   AST_RESET_FULL: assert property (disable iff (1'b0) $past(rst_in) &&
      !rst_in |-> func == pmm_pkg::FUNC_FULL)
      else $error("function level not full after reset");
   AST_MIN_OFF: assert property (mode_reg == pmm_pkg::PMM_MIN &&
      $stable(mode_reg) |-> !rf_enable_out && !sim_enable_out)
      else $error("minimum mode left radio or card on");
   AST_REJECT: assert property (ce_in && radio_cmd_in &&
      mode_reg == pmm_pkg::PMM_AIR |=> radio_cmd_reject_out && !rf_enable_out)
      else $error("radio command not rejected");
   AST_SLEEP_RX: assert property (in_sleep && $stable(mode_reg) |->
      paging_rx_enable_out)
      else $error("sleep lost receive path");
   AST_OFF_QUIET: assert property (in_off && $stable(mode_reg) |->
      !serial_enable_out && !rf_enable_out)
      else $error("serial active in power-down");
   AST_MASK: assert property (mask_active |-> !in_sleep &&
      !ring_indicator_out && !pin_air)
      else $error("shared pins acted during power-on mask");
   AST_MIN_FIRST: assert property (ce_in && func == pmm_pkg::FUNC_MIN &&
      !in_off && !pdown_pulse |=> mode_reg == pmm_pkg::PMM_MIN)
      else $error("minimum level did not take precedence");

   COV_SLEEP: cover property ($rose(in_sleep));
   COV_WAKE: cover property (in_sleep ##1 !in_sleep);
   COV_AIR: cover property (mode_reg == pmm_pkg::PMM_AIR);
   COV_POWER_ON: cover property (in_off ##1 !in_off);
endmodule

// [sim/pmm_host_model.sv]
// Host processor model driving the wake, sleep and power pins
`timescale 1ns/1ns
module pmm_host_model (
   input  wire logic mclk_in,
   output logic      terminal_ready_out,
   output logic      usb_suspend_out,
   output logic      usb_bus_power_out,
   output logic      radio_disable_n_out,
   output logic      power_key_n_out
);
   initial begin
      terminal_ready_out = 1'b0;
      usb_suspend_out = 1'b0;
      usb_bus_power_out = 1'b1;
      // Idle level of a pulled-up pin
      radio_disable_n_out = 1'b1;
      power_key_n_out = 1'b1;
   end
   task automatic set_pins(input logic t, s, p, a);
      @(posedge mclk_in);
      terminal_ready_out <= t;
      usb_suspend_out <= s;
      usb_bus_power_out <= p;
      radio_disable_n_out <= a;
   endtask
   task automatic press_key(input int n);
      @(posedge mclk_in);
      power_key_n_out <= 1'b0;
      repeat (n) @(posedge mclk_in);
      power_key_n_out <= 1'b1;
   endtask
endmodule

// [sim/tb_pmm_top.sv]
// Self-checking bench for the power mode manager
`timescale 1ns/1ns
module tb_pmm_top;
   localparam int MASK = 20;
   localparam int KEY  = 10;
   logic        mclk_in = 1'b0;
   logic        rst_in  = 1'b1;
   logic        cyc = 1'b0;
   logic        we  = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wd  = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic [2:0]  pls = 3'h0;
   logic        term, susp, vbus, air_n, key_n;
   logic        ring, rwake, rf, sim, page, ser, rej;
   logic [2:0]  mode;
   int          error_cnt = 0;
   int          checked = 0;
   int          rej_cnt = 0;
   always #25 mclk_in = ~mclk_in;
   always @(posedge mclk_in) if (rej === 1'b1) rej_cnt <= rej_cnt + 1;
   pmm_host_model pmm_host_model_i (.mclk_in(mclk_in),
      .terminal_ready_out(term), .usb_suspend_out(susp),
      .usb_bus_power_out(vbus), .radio_disable_n_out(air_n),
      .power_key_n_out(key_n));
   pmm_top #(.MASK_CYCLES(MASK), .KEY_CYCLES(KEY)) pmm_top_i (
      .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1),
      .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(4'hF), .wb_dat_in(wd), .wb_dat_out(rdat),
      .wb_ack_out(ack), .terminal_ready_in(term), .host_ready_in(1'b1),
      .radio_disable_n_in(air_n), .usb_suspend_in(susp),
      .usb_bus_power_sense_in(vbus), .usb_data_in(pls[2]),
      .unsolicited_report_in(pls[1]), .radio_cmd_in(pls[0]),
      .power_key_n_in(key_n), .ring_indicator_out(ring),
      .usb_remote_wakeup_out(rwake), .rf_enable_out(rf),
      .sim_enable_out(sim), .paging_rx_enable_out(page),
      .serial_enable_out(ser), .radio_cmd_reject_out(rej),
      .mode_out(mode));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Waits for ack without assuming a latency
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge mclk_in);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge mclk_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat;
      if (n >= 20) chk(32'h0, 32'h1, "no ack");
      cyc <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      chk(r, e, "read");
   endtask
   task automatic pulse(input int b);
      @(posedge mclk_in);
      pls[b] <= 1'b1;
      @(posedge mclk_in);
      pls <= 3'h0;
      repeat (3) @(posedge mclk_in);
   endtask
   task automatic cm(input pmm_pkg::pmm_mode_e e);
      repeat (3) @(posedge mclk_in);
      chk({29'h0, mode}, {29'h0, e}, "mode");
   endtask
   task automatic hp(input logic t, s, p, a);
      pmm_host_model_i.set_pins(t, s, p, a);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset_mask;
      chk({28'h0, rf, sim, page, ser}, 32'hF, "enables");
      cm(pmm_pkg::PMM_FULL);
      pulse(1);
      chk({31'h0, ring}, 32'h0, "ring in mask");
      rd(pmm_pkg::FUNC_OFS, 32'h1);
      rd(pmm_pkg::CTRL_OFS, 32'h0);
      rd(4'h2, 32'h0);
      repeat (MASK) @(posedge mclk_in);
      chk({31'h0, ring}, 32'h1, "ring after mask");
      wr(pmm_pkg::CMD_OFS, 32'h2);
      cm(pmm_pkg::PMM_FULL);
      chk({31'h0, ring}, 32'h0, "ring cleared");
   endtask
   task automatic t_func;
      wr(pmm_pkg::FUNC_OFS, 32'h0);
      cm(pmm_pkg::PMM_MIN);
      chk({30'h0, rf, sim}, 32'h0, "min enables");
      rd(pmm_pkg::STAT_OFS, 32'h81);
      pulse(0);
      chk(rej_cnt, 1, "reject min");
      wr(pmm_pkg::FUNC_OFS, 32'h4);
      cm(pmm_pkg::PMM_AIR);
      chk({30'h0, rf, sim}, 32'h1, "air enables");
      pulse(0);
      chk(rej_cnt, 2, "reject air");
      wr(pmm_pkg::FUNC_OFS, 32'h3);
      rd(pmm_pkg::FUNC_OFS, 32'h4);
      wr(pmm_pkg::FUNC_OFS, 32'h1);
      cm(pmm_pkg::PMM_FULL);
      pulse(0);
      chk(rej_cnt, 2, "no reject full");
   endtask
   task automatic t_airpin;
      hp(1'b0, 1'b0, 1'b1, 1'b0);
      cm(pmm_pkg::PMM_FULL);
      wr(pmm_pkg::CTRL_OFS, 32'h2);
      cm(pmm_pkg::PMM_AIR);
      wr(pmm_pkg::FUNC_OFS, 32'h0);
      cm(pmm_pkg::PMM_MIN);
      wr(pmm_pkg::FUNC_OFS, 32'h1);
      hp(1'b0, 1'b0, 1'b1, 1'b1);
      cm(pmm_pkg::PMM_FULL);
      wr(pmm_pkg::CTRL_OFS, 32'h0);
   endtask
   task automatic t_uart;
      hp(1'b1, 1'b0, 1'b1, 1'b1);
      cm(pmm_pkg::PMM_FULL);
      wr(pmm_pkg::CTRL_OFS, 32'h1);
      cm(pmm_pkg::PMM_SLEEP);
      chk({31'h0, page}, 32'h1, "paging");
      pulse(1);
      chk({31'h0, ring}, 32'h1, "ring uart");
      hp(1'b0, 1'b0, 1'b1, 1'b1);
      cm(pmm_pkg::PMM_FULL);
      wr(pmm_pkg::CMD_OFS, 32'h2);
   endtask
   task automatic t_usb;
      wr(pmm_pkg::CTRL_OFS, 32'hD);
      hp(1'b1, 1'b0, 1'b1, 1'b1);
      cm(pmm_pkg::PMM_FULL);
      hp(1'b1, 1'b1, 1'b1, 1'b1);
      cm(pmm_pkg::PMM_SLEEP);
      pulse(1);
      chk({30'h0, ring, rwake}, 32'h1, "remote wake");
      pulse(2);
      cm(pmm_pkg::PMM_FULL);
      wr(pmm_pkg::CMD_OFS, 32'h2);
      hp(1'b1, 1'b0, 1'b1, 1'b1);
      wr(pmm_pkg::CTRL_OFS, 32'h5);
      hp(1'b1, 1'b1, 1'b1, 1'b1);
      cm(pmm_pkg::PMM_SLEEP);
      pulse(1);
      chk({30'h0, ring, rwake}, 32'h2, "ring usb");
      wr(pmm_pkg::CMD_OFS, 32'h2);
      pulse(2);
      cm(pmm_pkg::PMM_FULL);
      // Clearing suspend lifts the re-entry block
      hp(1'b1, 1'b0, 1'b1, 1'b1);
      cm(pmm_pkg::PMM_FULL);
      hp(1'b1, 1'b0, 1'b0, 1'b1);
      cm(pmm_pkg::PMM_SLEEP);
      hp(1'b1, 1'b0, 1'b1, 1'b1);
      cm(pmm_pkg::PMM_FULL);
      hp(1'b0, 1'b0, 1'b1, 1'b1);
      wr(pmm_pkg::CTRL_OFS, 32'h0);
   endtask
   task automatic t_pdown;
      wr(pmm_pkg::CMD_OFS, 32'h1);
      cm(pmm_pkg::PMM_OFF);
      chk({31'h0, ser}, 32'h0, "serial off");
      pmm_host_model_i.press_key(KEY - 2);
      cm(pmm_pkg::PMM_OFF);
      pmm_host_model_i.press_key(KEY + 2);
      cm(pmm_pkg::PMM_FULL);
      chk({31'h0, ser}, 32'h1, "serial on");
   endtask
   initial begin
      repeat (8) @(posedge mclk_in);
      rst_in <= 1'b0;
      t_reset_mask();
      t_func();
      t_airpin();
      t_uart();
      t_usb();
      t_pdown();
      tally_and_finish();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #(50 * 3000);
      error_cnt++;
      tally_and_finish();
   end
endmodule
